/* hdl/ssc_slave.sv */
`default_nettype none
// ==========================================================
module ssc_slave
  import ssc_pkg::*;
(
  input  wire logic                clk,                  // System clock, 50 MHz
  input  wire logic                resetn,               // Synchronous reset, active low
  input  wire ssc_pins_type        pins,                 // Serial pins from the master
  input  wire logic                streaming_state,      // Sensor is streaming
  input  wire logic                frame_start,          // One-cycle frame start pulse
  output logic                     miso_out,             // Serial return data
  output logic                     miso_oe,              // Return line driven
  output logic [WORD_W-1:0]        line_length_active,   // Line length in use
  output logic                     sub_lvds_active       // Reduced-swing outputs in use
);
  // ==========================================================
  // Pin synchronisers
  ssc_pins_type pins_f;
  logic [2:0]   pin_vec;
  logic [2:0]   pin_lvl;
  localparam logic [2:0] PIN_RST = 3'b110;

  // All three pins share one latency, so mosi still lines up with its sck rise;
  // the price is about four clocks per pin edge, which caps the serial clock rate
  assign pin_vec = pins;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      ssc_pin_filter #(.RST_VAL(PIN_RST[gi])) u_filt (
        .clk    (clk),
        .resetn (resetn),
        .pin    (pin_vec[gi]),
        .level  (pin_lvl[gi])
      );
    end
  endgenerate
  assign pins_f = pin_lvl;

  // ==========================================================
  // Edge detection and decode
  logic               sck_prev;
  logic               stream_prev;
  wire                selected   = !pins_f.csn_n;
  wire                sck_rise   = selected && pins_f.sck && !sck_prev;
  wire                sck_fall   = selected && !pins_f.sck && sck_prev;
  wire                stream_rise = streaming_state && !stream_prev;

  ssc_phase_type      phase;
  ssc_phase_type      next_phase;
  logic [CNT_W-1:0]   bit_cnt;
  logic [WORD_W-1:0]  shift_in;
  logic [WORD_W-1:0]  addr_word;
  logic [WORD_W-1:0]  rd_word;
  logic [WORD_W-1:0]  len_shadow;
  logic [WORD_W-1:0]  sel_shadow;

  wire [CNT_W-1:0]    next_cnt   = bit_cnt + 6'h01;
  wire [WORD_W-1:0]   next_shift = {shift_in[WORD_W-2:0], pins_f.mosi};
  wire                addr_done  = sck_rise && (next_cnt == BITS_ADDR);
  wire                word_done  = sck_rise && (next_cnt == BITS_TOTAL);
  wire                is_read    = addr_word[ADDR_READ_BIT];
  wire [14:0]         reg_idx    = addr_word[14:0];
  wire [14:0]         new_idx    = next_shift[14:0];
  wire                commit     = word_done && !is_read;
  wire                hit_len    = (reg_idx == OFS_LINE_LENGTH);
  wire                hit_sel    = (reg_idx == OFS_OUT_SIGNAL);
  // Fetch delay is zero: the shadow word is latched as the address completes
  wire [WORD_W-1:0]   fetch_word =
    (new_idx == OFS_LINE_LENGTH) ? len_shadow :
    (new_idx == OFS_OUT_SIGNAL)  ? sel_shadow : 16'h0000;
  wire [3:0]          out_idx    = 4'hF - bit_cnt[3:0];

  // ==========================================================
  // Phase sequencing
  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE: if (selected) next_phase = PH_ADDR;
      PH_ADDR: begin
        if (!selected) next_phase = PH_IDLE;
        else if (addr_done) next_phase = PH_DATA;
      end
      PH_DATA: begin
        if (!selected) next_phase = PH_IDLE;
        else if (word_done) next_phase = PH_DONE;
      end
      PH_DONE: if (!selected) next_phase = PH_IDLE;
      default: next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase       <= PH_IDLE;
      sck_prev    <= 1'b1;
      stream_prev <= 1'b0;
    end else begin
      phase       <= next_phase;
      sck_prev    <= pins_f.sck;
      stream_prev <= streaming_state;
    end
  end

  // ==========================================================
  // Shift engine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_cnt   <= 6'h00;
      shift_in  <= 16'h0000;
      addr_word <= 16'h0000;
      rd_word   <= 16'h0000;
    end else if (!selected) begin
      bit_cnt   <= 6'h00;
    end else if (sck_rise && phase != PH_DONE) begin
      bit_cnt   <= next_cnt;
      shift_in  <= next_shift;
      if (addr_done) begin
        addr_word <= next_shift;
        rd_word   <= fetch_word;
      end
    end
  end

  // Return line changes on falling edges during a read's data half, and clears on deselect
  always_ff @(posedge clk) begin
    if (!resetn) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else if (!selected) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else if (sck_fall && phase == PH_DATA && is_read) begin
      miso_out <= rd_word[out_idx];
      miso_oe  <= 1'b1;
    end
  end

  // ==========================================================
  // Shadow and active copies
  // Only a complete word commits, so a cut transfer leaves both shadows alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      len_shadow <= RST_LINE_LENGTH;
      sel_shadow <= RST_OUT_SIGNAL;
    end else if (commit) begin
      if (hit_len) len_shadow <= next_shift;
      if (hit_sel) sel_shadow <= next_shift;
    end
  end

  // Line length only moves on the way back into streaming
  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_length_active <= RST_LINE_LENGTH;
      sub_lvds_active    <= RST_OUT_SIGNAL[OUT_SIGNAL_BIT];
    end else begin
      if (stream_rise) line_length_active <= len_shadow;
      if (frame_start || stream_rise) begin
        sub_lvds_active <= sel_shadow[OUT_SIGNAL_BIT];
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_miso_idle_desel: assert property (!selected |=> !miso_oe)
    else $error("return line driven while deselected");
  a_oe_read_only: assert property (miso_oe |-> is_read && phase != PH_ADDR)
    else $error("return line driven outside read data");
  a_commit_full_word: assert property (commit |-> selected && bit_cnt == 6'h1F)
    else $error("write committed before 32 bits");
  a_abort_no_commit: assert property (
    $rose(pins_f.csn_n) |-> ##1 $stable(len_shadow) && $stable(sel_shadow))
    else $error("shadow changed on abandoned transfer");
  a_shadow_gated: assert property (!commit |=>
                                   $stable(len_shadow) && $stable(sel_shadow))
    else $error("shadow changed without a write");
  a_read_fetch: assert property (addr_done && new_idx == OFS_LINE_LENGTH |=>
                                 rd_word == $past(len_shadow))
    else $error("read did not return shadow value");
  a_len_stream_hold: assert property (!stream_rise |=> $stable(line_length_active))
    else $error("line length changed outside streaming entry");
  a_len_load: assert property (stream_rise |=> line_length_active == $past(len_shadow))
    else $error("line length not loaded on streaming entry");
  a_sel_frame: assert property (
    frame_start |=> sub_lvds_active == $past(sel_shadow[OUT_SIGNAL_BIT]))
    else $error("output select not updated at frame start");
  a_sel_hold: assert property (
    !(frame_start || stream_rise) |=> $stable(sub_lvds_active))
    else $error("output select changed between frames");
  a_miso_on_fall: assert property (!sck_fall |=> $stable(miso_out) || !selected)
    else $error("return data changed off a falling edge");
  a_oe_after_fall: assert property ($rose(miso_oe) |-> $past(sck_fall))
    else $error("return line enabled off a falling edge");
  a_first_bit_msb: assert property (
    sck_fall && phase == PH_DATA && is_read && bit_cnt == BITS_ADDR |=>
    miso_out == rd_word[WORD_W-1])
    else $error("first return bit is not the top bit");
  a_cnt_clear_desel: assert property (!selected |=> bit_cnt == 6'h00)
    else $error("bit count kept across a deselect");
  a_phase_idle_desel: assert property (!selected |=> phase == PH_IDLE)
    else $error("transfer state kept across a deselect");
endmodule : ssc_slave
`default_nettype wire

/* hdl/ssc_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants and types
package ssc_pkg;
  localparam int          WORD_W          = 16;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  BITS_ADDR       = 6'h10;
  localparam logic [5:0]  BITS_TOTAL      = 6'h20;
  localparam int          SYNC_STAGES     = 3;
  // Register offsets
  localparam logic [14:0] OFS_LINE_LENGTH = 15'h0200;
  localparam logic [14:0] OFS_OUT_SIGNAL  = 15'h2449;
  // Address word field layout
  localparam int          ADDR_READ_BIT   = 15;
  // Reset values
  localparam logic [15:0] RST_LINE_LENGTH = 16'h0000;
  localparam logic [15:0] RST_OUT_SIGNAL  = 16'h0000;
  localparam int          OUT_SIGNAL_BIT  = 0;
  // Fetch allowances the master must grant (no wait is needed here)
  localparam int          CLK_MHZ         = 50;
  localparam int          FETCH_CFG_NS    = 1500;
  localparam int          FETCH_RUN_NS    = 4500;
  localparam int          FETCH_CFG_CYC   = FETCH_CFG_NS * CLK_MHZ / 1000;
  localparam int          FETCH_RUN_CYC   = FETCH_RUN_NS * CLK_MHZ / 1000;

  typedef struct packed {
    logic csn_n;
    logic sck;
    logic mosi;
  } ssc_pins_type;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_DONE = 4'b1000
  } ssc_phase_type;
endpackage : ssc_pkg
`default_nettype wire

/* hdl/ssc_pin_filter.sv */
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser with agreement filter
module ssc_pin_filter
  import ssc_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,     // System clock
  input  wire logic resetn,  // Synchronous reset, active low
  input  wire logic pin,     // Asynchronous pin level
  output logic      level    // Filtered level
);
  logic [SYNC_STAGES-1:0] stage;

  // The first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage <= {SYNC_STAGES{RST_VAL}};
      level <= RST_VAL;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule : ssc_pin_filter
`default_nettype wire

/* verif/ssc_host_model.sv */
`default_nettype none
// ==========================================================
// Host controller model: master side of the serial link
module ssc_host_model
  import ssc_pkg::*;
(
  input  wire logic       clk,   // System clock
  input  wire logic       miso,  // Resolved return line
  input  wire logic       streaming, // Sensor streaming: longer fetch allowance
  output var ssc_pins_type pins  // Serial pins to the slave
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pins = '{csn_n: 1'b1, sck: 1'b1, mosi: 1'b0};

  // Half periods of 4 cycles give a 160 ns clock at even duty
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk) pins.csn_n = 1'b0;
    for (int i = 0; i <= nbits; i++) begin
      // A read pauses after its address, clock high, for the fetch allowance of the current mode
      if (i == 16 && word[31]) begin
        repeat (streaming ? FETCH_RUN_CYC : FETCH_CFG_CYC) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      // Data is taken a full bit after the fall that launched it
      if (i > 16) rd = {rd[14:0], miso};
      if (i == nbits) break;
      pins.sck  = 1'b0;
      pins.mosi = word[31-i];
      repeat (4) @(negedge clk);
      pins.sck = 1'b1;
    end
    pins.csn_n = 1'b1;
    pins.mosi  = ~pins.mosi;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : ssc_host_model
`default_nettype wire

/* verif/tb_ssc_slave.sv */
`default_nettype none
// ==========================================================
// Register access tests over the serial link
module tb_ssc_slave
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk             = 1'b0;
  logic              resetn          = 1'b0;
  logic              streaming_state = 1'b0;
  logic              frame_start     = 1'b0;
  logic              miso_last       = 1'b0;
  logic              miso_out;
  logic              miso_oe;
  logic              sub_lvds_active;
  logic [WORD_W-1:0] line_length_active;
  logic [15:0]       rd;
  ssc_pins_type      pins;
  wire logic         miso_line;
  int                num_errors      = 0;
  int                samples_checked = 0;

  initial forever #10 clk = ~clk;

  // Undriven line shows the inverse of its last value
  always @(posedge clk) if (miso_oe) miso_last <= miso_out;
  assign miso_line = miso_oe ? miso_out : ~miso_last;

  ssc_slave dut_u (
    .clk(clk), .resetn(resetn), .pins(pins), .streaming_state(streaming_state),
    .frame_start(frame_start), .miso_out(miso_out), .miso_oe(miso_oe),
    .line_length_active(line_length_active), .sub_lvds_active(sub_lvds_active)
  );
  ssc_host_model host_u (
    .clk(clk), .miso(miso_line), .streaming(streaming_state), .pins(pins)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic pulse_frame();
    @(negedge clk) frame_start = 1'b1;
    @(negedge clk) frame_start = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse_frame

  task automatic set_stream(input logic v);
    @(negedge clk) streaming_state = v;
    repeat (2) @(negedge clk);
  endtask : set_stream

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk("line length reset", 16'h0000, line_length_active);
    chk("select reset", 16'h0000, {15'h0000, sub_lvds_active});
    set_stream(1'b1);
    host_u.xfer({16'h0200, 16'h1234}, 32, rd);
    chk("line length held", 16'h0000, line_length_active);
    host_u.xfer({16'h8200, 16'h0000}, 32, rd);
    chk("shadow readback", 16'h1234, rd);
    pulse_frame();
    chk("line length at frame", 16'h0000, line_length_active);
    set_stream(1'b0);
    set_stream(1'b1);
    chk("line length applied", 16'h1234, line_length_active);
    host_u.xfer({16'h0200, 16'hBEEF}, 20, rd);
    host_u.xfer({16'h8200, 16'h0000}, 32, rd);
    chk("abort readback", 16'h1234, rd);
    set_stream(1'b0);
    host_u.xfer({16'h2449, 16'h0001}, 32, rd);
    chk("select held", 16'h0000, {15'h0000, sub_lvds_active});
    pulse_frame();
    chk("select applied", 16'h0001, {15'h0000, sub_lvds_active});
    host_u.xfer({16'hA449, 16'h0000}, 32, rd);
    chk("select readback", 16'h0001, rd);
    host_u.xfer({16'h8123, 16'h0000}, 32, rd);
    chk("unmapped read", 16'h0000, rd);
    chk("return line idle", 16'h0000, {15'h0000, miso_oe});
    report_and_stop();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule : tb_ssc_slave
`default_nettype wire
